// ===== verilog/ast_consts.svh
// Constants of the scan trigger control block
// Behaviour
// - A level trigger (select code 00010) starts no burst scans in debug.
// - With the turbo link enable set a trigger starts no conversion; a fault shows.
// - A software or edge trigger during a running scan restarts the list at the start.
// - A restarted list sets the end-of-scan ready status when it completes, beside the restart flag.
// - Analog input twenty six is never sampled, even when selected.
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AST_REG_CTRL    8'h00
`define AST_REG_SCAN    8'h04
`define AST_REG_SAMPLE_TIME_COUNT    8'h08
`define AST_REG_STAT    8'h0c
`define AST_REG_DATA    8'h10
`define AST_REG_TRIG    8'h14
// ----------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------
`define AST_CTRL_TURBO  1
`define AST_CTRL_TSEL   6:2
`define AST_TSEL_SW     5'h01
`define AST_TSEL_LEVEL  5'h02
`define AST_TSEL_EDGE   5'h03
`define AST_BAD_CH      26
`define AST_ST_EOS      0
`define AST_ST_RESTART  1
`define AST_ST_TURBO    2
`define AST_SAMPLE_TIME_COUNT_RST    8'h04
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AST_CLK_NS      25
`define AST_TAD_NS      100
`define AST_TAD_CYC     ((`AST_TAD_NS + `AST_CLK_NS - 1) / `AST_CLK_NS)
`define AST_CONV_TAD    8'h0d
`endif

// ===== verilog/ast_pkg.sv
// Types of the scan trigger control block
package ast_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} ast_state_t;
   typedef struct packed {
      logic [4:0]  ch;
      logic [11:0] code;
   } ast_result_t;
endpackage

// ===== verilog/ast_scan_trigger.sv
// Scan trigger control with its result FIFO
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ast_consts.svh"

module ast_fifo #(
   parameter int W = 17,
   parameter int D = 32
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst_b,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  wp_nxt;
   logic [AW:0]  rp_r;
   logic [AW:0]  rp_nxt;
   logic         push;
   logic         pop;

   assign o_ready = !((wp_r[AW] != rp_r[AW]) &&
                      (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign o_valid = (wp_r != rp_r);
   assign o_data  = mem[rp_r[AW-1:0]];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_comb
   begin
      wp_nxt = wp_r + (AW+1)'(push);
      rp_nxt = rp_r + (AW+1)'(pop);
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
      if (push)
         mem[wp_r[AW-1:0]] <= i_data;
   end
endmodule

module ast_scan_trigger (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   input  wire logic        i_trig_pin,
   input  wire logic        i_debug_mode,
   input  wire logic [11:0] i_conv_code,
   output logic [4:0]       o_chan_sel,
   output logic             o_sampling,
   output logic             o_converting
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [2:0] TAD_LAST = 3'(`AST_TAD_CYC - 1);
   ast_pkg::ast_state_t  state_r;
   ast_pkg::ast_state_t  state_nxt;
   ast_pkg::ast_result_t res;
   ast_pkg::ast_result_t head;
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic [31:0] scan_r;
   logic [31:0] scan_nxt;
   logic [7:0]  sample_time_count_r;
   logic [7:0]  sample_time_count_nxt;
   logic [2:0]  stat_r;
   logic [2:0]  stat_nxt;
   logic [31:0] rdata_nxt;
   logic [4:0]  ch_r;
   logic [4:0]  ch_nxt;
   logic [7:0]  cnt_r;
   logic [7:0]  cnt_nxt;
   logic [2:0]  div_r;
   logic [2:0]  div_nxt;
   logic [2:0]  pin_r;
   logic        tad_tick;
   logic        trig;
   logic        push;
   logic        f_ready;
   logic        f_valid;
   logic        pop;
   logic [31:0] mask;
   logic [5:0]  first;
   logic [5:0]  next;
   logic [4:0]  tsel;
   logic        set_eos;
   logic        set_rst;
   logic        set_turbo;

   // Lowest selected channel at or above a start index
   function automatic logic [5:0] find_ch(input logic [31:0] m,
                                          input logic [5:0]  from);
      logic [5:0] r;
      r = '0;
      for (int i = 31; i >= 0; i--)
         if (m[i] && (6'(i) >= from))
            r = {1'b1, 5'(i)};
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchroniser and converter clock divider
   // ----------------------------------------------------------------
   always_comb
   begin
      div_nxt = (div_r == TAD_LAST) ? 3'h0 : div_r + 3'h1;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         div_r <= 3'h0;
         pin_r <= 3'h0;
      end
      else
      begin
         div_r <= div_nxt;
         pin_r <= {pin_r[1:0], i_trig_pin};
      end
   end

   assign tad_tick = (div_r == TAD_LAST);

   // ----------------------------------------------------------------
   // Trigger qualification
   // ----------------------------------------------------------------
   assign tsel  = ctrl_r[`AST_CTRL_TSEL];
   assign mask  = scan_r & ~(32'h1 << `AST_BAD_CH);
   assign first = find_ch(mask, 6'h00);
   assign next  = find_ch(mask, {1'b0, ch_r} + 6'h01);

   always_comb
   begin
      trig = 1'b0;
      if (tsel == `AST_TSEL_SW)
         trig = i_wr && (i_addr == `AST_REG_TRIG);
      else if (tsel == `AST_TSEL_EDGE)
         trig = pin_r[1] && !pin_r[2];
      else if (tsel == `AST_TSEL_LEVEL)
         trig = pin_r[1] && !i_debug_mode &&
                (state_r == ast_pkg::ST_IDLE);
   end

   // ----------------------------------------------------------------
   // Scan sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      ch_nxt    = ch_r;
      cnt_nxt   = cnt_r;
      push      = 1'b0;
      set_eos   = 1'b0;
      set_rst   = 1'b0;
      set_turbo = 1'b0;
      if (trig && ctrl_r[`AST_CTRL_TURBO])
         set_turbo = 1'b1;
      else if (trig && first[5])
      begin
         set_rst   = (state_r != ast_pkg::ST_IDLE);
         state_nxt = ast_pkg::ST_SAMPLE;
         ch_nxt    = first[4:0];
         cnt_nxt   = 8'h00;
      end
      else if (tad_tick)
      begin
         case (state_r)
            ast_pkg::ST_SAMPLE:
            begin
               cnt_nxt = cnt_r + 8'h01;
               if ({1'b0, cnt_r} + 9'h001 >= {1'b0, sample_time_count_r})
               begin
                  state_nxt = ast_pkg::ST_CONV;
                  cnt_nxt   = 8'h00;
               end
            end
            ast_pkg::ST_CONV:
            begin
               if (cnt_r + 8'h01 < `AST_CONV_TAD)
                  cnt_nxt = cnt_r + 8'h01;
               else if (f_ready)
               begin
                  push    = 1'b1;
                  cnt_nxt = 8'h00;
                  if (next[5])
                  begin
                     state_nxt = ast_pkg::ST_SAMPLE;
                     ch_nxt    = next[4:0];
                  end
                  else
                  begin
                     state_nxt = ast_pkg::ST_IDLE;
                     set_eos   = 1'b1;
                  end
               end
            end
            default:
               cnt_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         state_r <= ast_pkg::ST_IDLE;
         ch_r    <= 5'h00;
         cnt_r   <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         ch_r    <= ch_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign o_chan_sel   = ch_r;
   assign o_sampling   = (state_r == ast_pkg::ST_SAMPLE);
   assign o_converting = (state_r == ast_pkg::ST_CONV);

   // ----------------------------------------------------------------
   // Result FIFO
   // ----------------------------------------------------------------
   assign res.ch   = ch_r;
   assign res.code = i_conv_code;
   assign pop      = i_rd && (i_addr == `AST_REG_DATA);

   ast_fifo #(
      .W (17),
      .D (32)
   ) u_fifo (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_valid (push),
      .o_ready (f_ready),
      .i_data  (res),
      .o_valid (f_valid),
      .i_ready (pop),
      .o_data  (head)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      scan_nxt = scan_r;
      sample_time_count_nxt = sample_time_count_r;
      stat_nxt = stat_r;
      if (i_wr && (i_addr == `AST_REG_CTRL))
         ctrl_nxt = {25'h0, i_wdata[6:0]};
      else if (i_wr && (i_addr == `AST_REG_SCAN))
         scan_nxt = i_wdata;
      else if (i_wr && (i_addr == `AST_REG_SAMPLE_TIME_COUNT))
         sample_time_count_nxt = i_wdata[7:0];
      else if (i_wr && (i_addr == `AST_REG_STAT))
         stat_nxt = stat_r & ~i_wdata[2:0];
      stat_nxt[`AST_ST_EOS]     = stat_nxt[`AST_ST_EOS] | set_eos;
      stat_nxt[`AST_ST_RESTART] = stat_nxt[`AST_ST_RESTART] | set_rst;
      stat_nxt[`AST_ST_TURBO]   = stat_nxt[`AST_ST_TURBO] | set_turbo;
      rdata_nxt = 32'h0;
      if (!i_rd)
         rdata_nxt = 32'h0;
      else if (i_addr == `AST_REG_CTRL)
         rdata_nxt = ctrl_r;
      else if (i_addr == `AST_REG_SCAN)
         rdata_nxt = scan_r;
      else if (i_addr == `AST_REG_SAMPLE_TIME_COUNT)
         rdata_nxt = {24'h0, sample_time_count_r};
      else if (i_addr == `AST_REG_STAT)
         rdata_nxt = {26'h0, f_valid, (state_r != ast_pkg::ST_IDLE),
                      !f_ready, stat_r};
      else if (i_addr == `AST_REG_DATA)
         rdata_nxt = f_valid ? {1'b1, 14'h0, head} : 32'h0;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         ctrl_r  <= 32'h0;
         scan_r  <= 32'h0;
         sample_time_count_r  <= `AST_SAMPLE_TIME_COUNT_RST;
         stat_r  <= 3'h0;
         o_rdata <= 32'h0;
      end
      else
      begin
         ctrl_r  <= ctrl_nxt;
         scan_r  <= scan_nxt;
         sample_time_count_r  <= sample_time_count_nxt;
         stat_r  <= stat_nxt;
         o_rdata <= rdata_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== sim/ast_analog_model.sv
// Analog input model for the scan trigger control block
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Code per converted channel
// ----------------------------------------------------------------
module ast_analog_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic [4:0] i_chan_sel,
   input  wire logic       i_converting,
   output logic [11:0]     o_conv_code
);
   // Code toggles outside conversion, never a stale value
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
         o_conv_code <= 12'h000;
      else if (i_converting)
         o_conv_code <= {7'h50, i_chan_sel};
      else
         o_conv_code <= ~o_conv_code;
   end
endmodule
`default_nettype wire

// ===== sim/ast_scan_trigger_props.sv
// Port checker of the scan trigger control block
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module ast_scan_trigger_props (
   input wire logic        i_clock,
   input wire logic        i_rst_b,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_trig_pin,
   input wire logic        i_debug_mode,
   input wire logic [11:0] i_conv_code,
   input wire logic [4:0]  o_chan_sel,
   input wire logic        o_sampling,
   input wire logic        o_converting
);
   logic [4:0]  tsel_r;
   logic        turbo_r;
   logic [31:0] mask_r;
   logic [4:0]  pin_r;
   logic [7:0]  conv_r;
   logic        idle;
   logic        sw_trig;
   assign idle = !o_sampling && !o_converting;
   assign sw_trig = i_wr && i_addr == 8'h14 && tsel_r == 5'h01 && !turbo_r;
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         tsel_r  <= 5'h00;
         turbo_r <= 1'b0;
         mask_r  <= 32'h0;
         pin_r   <= 5'h00;
         conv_r  <= 8'h00;
      end
      else
      begin
         if (i_wr && i_addr == 8'h00)
         begin
            tsel_r  <= i_wdata[6:2];
            turbo_r <= i_wdata[1];
         end
         if (i_wr && i_addr == 8'h04)
            mask_r <= i_wdata;
         pin_r  <= {pin_r[3:0], i_trig_pin};
         conv_r <= o_converting ? conv_r + {7'h0, conv_r != 8'hff} : 8'h00;
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);
   AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside reply cycle");
   AST_NO_26: assert property (!idle |-> o_chan_sel != 5'h1a)
      else $error("input 26 selected");
   AST_SW_START: assert property (sw_trig && idle &&
      (mask_r & ~32'h0400_0000) != 32'h0 |=> o_sampling)
      else $error("software trigger did not start");
   AST_RESTART: assert property (sw_trig && !idle |=>
      o_sampling && o_chan_sel <= $past(o_chan_sel))
      else $error("early trigger did not restart list");
   AST_TURBO: assert property (turbo_r && idle |=> !o_sampling)
      else $error("scan ran with turbo link");
   AST_DEBUG: assert property ((i_trig_pin && !i_wr)[*6] ##0
      (i_debug_mode && idle) |=> !o_sampling)
      else $error("level trigger scanned in debug");
   AST_ASCEND: assert property ($rose(o_sampling) &&
      $past(o_converting) && !$past(i_wr) && pin_r == 5'h00
      |-> o_chan_sel > $past(o_chan_sel))
      else $error("channels not ascending");
   AST_CONV_LEN: assert property ($fell(o_converting) && !o_sampling
      |-> conv_r >= 8'd48)
      else $error("conversion cut short");
endmodule
bind ast_scan_trigger ast_scan_trigger_props i_props (
   .i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_trig_pin(i_trig_pin), .i_debug_mode(i_debug_mode),
   .i_conv_code(i_conv_code), .o_chan_sel(o_chan_sel),
   .o_sampling(o_sampling), .o_converting(o_converting));
`default_nettype wire

// ===== sim/ast_scan_trigger_test.sv
// Testbench of the scan trigger control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
   $display("[ERR] %s exp %0h got %0h", n, e, s); end end
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module ast_scan_trigger_test;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        trig_pin = 1'b0;
   logic        debug_mode = 1'b0;
   logic [31:0] rdata;
   logic [11:0] conv_code;
   logic [4:0]  chan_sel;
   logic        sampling;
   logic        converting;
   int          fails = 0;
   int          compares = 0;
   int          cycles = 0;
   int          n;
   ast_scan_trigger i_ast_scan_trigger (.i_clock(clock), .i_rst_b(rst_b),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_trig_pin(trig_pin), .i_debug_mode(debug_mode),
      .i_conv_code(conv_code), .o_chan_sel(chan_sel),
      .o_sampling(sampling), .o_converting(converting));
   ast_analog_model i_ast_analog_model (.i_clock(clock), .i_rst_b(rst_b),
      .i_chan_sel(chan_sel), .i_converting(converting),
      .o_conv_code(conv_code));
   initial
   begin
      forever #12.5 clock = ~clock;
   end
   function automatic logic [31:0] word(input logic [4:0] c);
      return {1'b1, 14'h0, c, 7'h50, c};
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      d = rdata;
   endtask
   task automatic chk_reg(input string s, input logic [7:0] a,
                          input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      `CHK(s, e, d);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      @(negedge clock);
      while ((sampling || converting) && k < 8000)
      begin
         @(negedge clock);
         k++;
      end
      `CHK("idle", 1'b1, k < 8000);
   endtask
   task automatic drain(inout int c);
      logic [31:0] d;
      repeat (64)
      begin
         rd_reg(8'h10, d);
         if (d[31] !== 1'b1)
            break;
         c++;
      end
   endtask
   task automatic t_reset();
      chk_reg("ctrl", 8'h00, 32'h0);
      chk_reg("scan", 8'h04, 32'h0);
      chk_reg("sample_time_count", 8'h08, 32'h4);
      chk_reg("stat", 8'h0c, 32'h0);
      chk_reg("hole", 8'h20, 32'h0);
      wr_reg(8'h08, 32'hd);
      chk_reg("samc13", 8'h08, 32'hd);
   endtask
   task automatic t_scan();
      wr_reg(8'h08, 32'h8);
      wr_reg(8'h04, 32'h0400_0009);
      wr_reg(8'h00, 32'h4);
      wr_reg(8'h14, 32'h0);
      wait_idle();
      chk_reg("stat", 8'h0c, 32'h21);
      chk_reg("data0", 8'h10, word(5'h00));
      chk_reg("data3", 8'h10, word(5'h03));
      chk_reg("empty", 8'h10, 32'h0);
      wr_reg(8'h0c, 32'h7);
   endtask
   task automatic t_restart();
      wr_reg(8'h04, 32'h6);
      wr_reg(8'h14, 32'h0);
      n = 0;
      while (!(converting && chan_sel == 5'h02) && n < 4000)
      begin
         @(negedge clock);
         n++;
      end
      wr_reg(8'h14, 32'h0);
      chk_reg("stat_rs", 8'h0c, 32'h32);
      wait_idle();
      chk_reg("rs1", 8'h10, word(5'h01));
      chk_reg("rs1b", 8'h10, word(5'h01));
      chk_reg("rs2", 8'h10, word(5'h02));
      chk_reg("stat_end", 8'h0c, 32'h03);
      wr_reg(8'h0c, 32'h7);
   endtask
   task automatic t_turbo();
      wr_reg(8'h00, 32'h6);
      wr_reg(8'h14, 32'h0);
      repeat (10) @(negedge clock);
      `CHK("turbo", 1'b0, sampling);
      chk_reg("stat_tb", 8'h0c, 32'h04);
      wr_reg(8'h0c, 32'h7);
   endtask
   task automatic t_level();
      wr_reg(8'h04, 32'h1);
      wr_reg(8'h00, 32'h8);
      debug_mode <= 1'b1;
      trig_pin <= 1'b1;
      repeat (40) @(posedge clock);
      chk_reg("stat_dbg", 8'h0c, 32'h0);
      debug_mode <= 1'b0;
      n = 0;
      while (!sampling && n < 12)
      begin
         @(negedge clock);
         n++;
      end
      `CHK("level", 1'b1, sampling);
      @(posedge clock);
      trig_pin <= 1'b0;
      wait_idle();
      n = 0;
      drain(n);
      `CHK("lvl_words", 1, n);
      wr_reg(8'h0c, 32'h7);
   endtask
   task automatic t_edge();
      wr_reg(8'h00, 32'hc);
      trig_pin <= 1'b1;
      repeat (8) @(posedge clock);
      trig_pin <= 1'b0;
      wait_idle();
      chk_reg("edge", 8'h10, word(5'h00));
      wr_reg(8'h0c, 32'h7);
   endtask
   task automatic t_full();
      logic [31:0] d;
      wr_reg(8'h04, 32'hffff_ffff);
      wr_reg(8'h00, 32'h4);
      wr_reg(8'h14, 32'h0);
      wait_idle();
      wr_reg(8'h14, 32'h0);
      d = 32'h0;
      repeat (4000)
         if (d[3] !== 1'b1)
            rd_reg(8'h0c, d);
      `CHK("full", 1'b1, d[3]);
      n = 0;
      drain(n);
      wait_idle();
      drain(n);
      `CHK("words", 62, n);
      chk_reg("stat_fl", 8'h0c, 32'h01);
   endtask
   task automatic give_verdict();
      $display("TB: %0d checks, %0d mismatches", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fails++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_scan();
      t_restart();
      t_turbo();
      t_level();
      t_edge();
      t_full();
      give_verdict();
   end
endmodule
`default_nettype wire
